/* asc_serial_ctrl.sv */
/*
 Serial control and result shifter of a 12-bit sampling converter.
 Assumes the host is a mode-0 serial master far slower than mclk (>= 4 mclk
 per half period) and that the converter core answers with convDone.
*/
// Behaviour
// - The eight input bits are captured on the first eight rising clock edges; address valid rises after the fourth, the address settles after the eighth.
// - Sampling runs from the fourth falling clock edge to the last falling edge of the frame.
// - The result output is high impedance while chip select is high and driven only while it is low.
// - When chip select falls the first bit of the previous result is driven, MSB or LSB first as configured.
// - Each following falling clock edge advances the output to the next result bit.
// - In interrupt mode the status pin falls once the conversion is done and the result is ready.
// - In interrupt mode the low status is cleared by a rising clock edge.
// - In end-of-conversion mode the status pin goes low after the last falling edge and stays low until done.
// - On the last falling clock edge control passes to the conversion state machine.
// - Chip select falling resets counters and enables the port; rising disables input and clock.
// - In end-of-conversion mode the status pin returns high when conversion completes.
`default_nettype none
module asc_serial_ctrl
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Serial pins from the host
    input  wire asc_pkg::asc_pins_s       pinsIn,
    // Serial and status pins to the host
    output asc_pkg::asc_outs_s            pinsOut,
    // Mode straps from configuration
    input  wire logic                     lsbFirst,
    input  wire logic                     intMode,
    input  wire logic [4:0]               frameEdges,
    // Converter core
    output logic [ASC_ADDR_BITS-1:0]      muxAddr,
    output logic                          muxAddrValid,
    output logic [ASC_CMD_W-1:0]          commandByte,
    output logic                          sampling,
    output logic                          convStart,
    input  wire logic                     convDone,
    input  wire logic [ASC_RES_W-1:0]     convResult
);
    // Registered state and the combinational next state
    asc_pins_s            syncPins;
    asc_state_e           stateQ;
    asc_state_e           stateD;
    logic                 csNPrevQ;
    logic                 clkPrevQ;
    logic [4:0]           riseCntQ;
    logic [4:0]           fallCntQ;
    logic [ASC_CMD_W-1:0] cmdQ;
    logic [ASC_RES_W-1:0] resultQ;
    logic [ASC_RES_W-1:0] shiftQ;
    logic                 samplingQ;
    logic                 statusQ;
    logic                 addrValidQ;
    logic                 convStartQ;

    // Picks the bit that leaves first for the configured order
    function automatic logic lead_bit(input logic lsb, input logic [ASC_RES_W-1:0] v);
        return lsb ? v[0] : v[ASC_RES_W-1];
    endfunction

    // Moves the next bit into the leading place; the vacated end fills with zero
    function automatic logic [ASC_RES_W-1:0] step_word(input logic lsb, input logic [ASC_RES_W-1:0] v);
        return lsb ? {1'b0, v[ASC_RES_W-1:1]} : {v[ASC_RES_W-2:0], 1'b0};
    endfunction

    // The shifters and counters are sized for these widths only
    if (ASC_RES_W != 12) begin : gBadRes
        $error("asc_serial_ctrl: result width must be 12");
    end
    if (ASC_CMD_W != 8 || ASC_ADDR_BITS != 4) begin : gBadCmd
        $error("asc_serial_ctrl: command must be 8 bits with a 4-bit address");
    end

    asc_sync #(
        .W        (3)
    ) uSync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .asyncIn  (pinsIn),
        .resetVal (3'b100),
        .syncOut  (syncPins)
    );

    wire       csActive   = !syncPins.csN;
    wire       csFall     = csNPrevQ && !syncPins.csN;
    wire       clkRise    = csActive && !clkPrevQ && syncPins.ioClk;
    wire       clkFall    = csActive && clkPrevQ && !syncPins.ioClk;
    wire       inFrame    = (stateQ == ASC_FRAME);
    wire       frameRise  = clkRise && inFrame;
    wire       frameFall  = clkFall && inFrame;
    wire       convFinish = convDone && (stateQ == ASC_CONV);
    wire [4:0] fallNext   = fallCntQ + 5'h01;
    // A frame with fewer falls than frameEdges never hands over; the next select fall restarts it
    wire       lastFall   = clkFall && (fallNext == frameEdges);
    wire       firstOut   = lead_bit(lsbFirst, resultQ);

    // A select fall outside IDLE leaves the state alone; the counters still restart
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            ASC_IDLE:  if (csFall) stateD = ASC_FRAME;
            ASC_FRAME: if (lastFall) stateD = ASC_CONV;
            ASC_CONV:  if (convDone) stateD = ASC_IDLE;
            default:   stateD = ASC_IDLE;
        endcase
    end

    // Edge detectors start at the idle pin levels so reset never fakes an edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ   <= ASC_IDLE;
            csNPrevQ <= 1'b1;
            clkPrevQ <= 1'b0;
        end else begin
            stateQ   <= stateD;
            csNPrevQ <= syncPins.csN;
            clkPrevQ <= syncPins.ioClk;
        end
    end

    // Edge counters restart on every chip-select fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            riseCntQ <= 5'h00;
            fallCntQ <= 5'h00;
        end else if (csFall) begin
            riseCntQ <= 5'h00;
            fallCntQ <= 5'h00;
        end else begin
            // Rises past 31 would wrap, but the command stops shifting after eight
            if (frameRise) riseCntQ <= riseCntQ + 5'h01;
            if (frameFall) fallCntQ <= fallNext;
        end
    end

    // Command byte: MSB first on the first eight rises
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmdQ       <= 8'h00;
            addrValidQ <= 1'b0;
        end else if (csFall) begin
            addrValidQ <= 1'b0;
        end else if (frameRise && riseCntQ < 5'h08) begin
            cmdQ <= {cmdQ[ASC_CMD_W-2:0], syncPins.dataIn};
            if (riseCntQ == 5'h03) addrValidQ <= 1'b1;
        end
    end

    // Sampling window: fourth fall to last fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            samplingQ <= 1'b0;
        end else if (csFall || lastFall) begin
            samplingQ <= 1'b0;
        end else if (frameFall && fallNext == 5'h04) begin
            samplingQ <= 1'b1;
        end
    end

    // Result latch and output shifter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resultQ <= ASC_RES_RST;
            shiftQ  <= ASC_RES_RST;
        end else begin
            // Stored only on a finish in CONV, so a stray done is ignored
            if (convFinish) resultQ <= convResult;
            if (csFall) begin
                shiftQ <= step_word(lsbFirst, resultQ);
            end else if (frameFall) begin
                shiftQ <= step_word(lsbFirst, shiftQ);
            end
        end
    end

    // Data comes from a flop so the pin never glitches between falls
    logic dataOutQ;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dataOutQ <= 1'b0;
        end else if (csFall) begin
            dataOutQ <= firstOut;
        end else if (frameFall) begin
            dataOutQ <= lead_bit(lsbFirst, shiftQ);
        end
    end

    // Status pin; a done in the same cycle as a clearing rise wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            statusQ    <= ASC_STAT_IDLE;
            convStartQ <= 1'b0;
        end else begin
            convStartQ <= lastFall;
            if (intMode) begin
                if (convFinish) statusQ <= 1'b0;
                else if (clkRise) statusQ <= 1'b1;
            end else begin
                if (lastFall) statusQ <= 1'b0;
                else if (convFinish) statusQ <= 1'b1;
            end
        end
    end

    // Enable follows the synchronised select: high impedance whenever the host lets go
    assign pinsOut.dataOut    = dataOutQ;
    assign pinsOut.dataOutOeN = syncPins.csN;
    assign pinsOut.statusPin  = statusQ;
    assign muxAddr            = cmdQ[ASC_ADDR_BITS-1:0];
    assign muxAddrValid       = addrValidQ;
    assign commandByte        = cmdQ;
    assign sampling           = samplingQ;
    assign convStart          = convStartQ;
endmodule // asc_serial_ctrl
`default_nettype wire

/* asc_pkg.sv */
/*
 Package for the converter serial control block: frame counts, idle status level,
 result widths and the structs that carry the serial input and output pin groups.
 Assumes one system clock; serial pins are sampled, not used as clocks.
*/
`default_nettype none
package asc_pkg;
    localparam int          ASC_RES_W      = 12;
    localparam int          ASC_CMD_W      = 8;
    localparam int          ASC_ADDR_BITS  = 4;
    localparam logic [4:0]  ASC_DEF_EDGES  = 5'h0C;
    localparam logic        ASC_STAT_IDLE  = 1'b1;
    localparam logic [11:0] ASC_RES_RST    = 12'h000;

    typedef enum logic [2:0] {
        ASC_IDLE  = 3'b001,
        ASC_FRAME = 3'b010,
        ASC_CONV  = 3'b100
    } asc_state_e;

    typedef struct packed {
        logic csN;
        logic ioClk;
        logic dataIn;
    } asc_pins_s;

    typedef struct packed {
        logic       dataOut;
        logic       dataOutOeN;
        logic       statusPin;
    } asc_outs_s;
endpackage : asc_pkg
`default_nettype wire

/* asc_sync.sv */
/*
 Two-flop synchroniser for a bundle of pin levels.
 Assumes inputs are asynchronous to mclk; output is safe for logic.
*/
`default_nettype none
module asc_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] asyncIn,
    input  wire logic [W-1:0] resetVal,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1Q;
    logic [W-1:0] stage2Q;

    if (W < 1) begin : gBadW
        $error("asc_sync: W must be positive");
    end

    // Reset value comes from a port, so it is loaded synchronously while reset is held and on the first edge after release
    logic armedQ;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            armedQ <= 1'b0;
        end else begin
            armedQ <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!armedQ) begin
            stage1Q <= resetVal;
            stage2Q <= resetVal;
        end else begin
            stage1Q <= asyncIn;
            stage2Q <= stage1Q;
        end
    end

    assign syncOut = stage2Q;
endmodule // asc_sync
`default_nettype wire

/* asc_serial_ctrl_chk.sv */
/* Port-level timing checks for asc_serial_ctrl.
 Assumes pin edges reach the logic two mclk after they change. */
`default_nettype none
module asc_serial_ctrl_chk
    import asc_pkg::*;
(
    // Clock, reset and pins
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire asc_pkg::asc_pins_s pinsIn,
    input wire asc_pkg::asc_outs_s pinsOut,
    // Mode and core side
    input wire logic               intMode,
    input wire logic               muxAddrValid,
    input wire logic               sampling,
    input wire logic               convStart,
    input wire logic               convDone
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Handoff is one start pulse, never a level
    sequence s_handoff;
        !sampling && convStart ##1 !convStart;
    endsequence
    property p_oe;
        !$stable(pinsIn.csN) |-> ##2 pinsOut.dataOutOeN == $past(pinsIn.csN, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable does not follow select");
    property p_start;
        $fell(sampling) |-> s_handoff;
    endproperty
    a_start: assert property (p_start) else $error("no start pulse after frame");
    property p_eoc;
        $fell(sampling) && !intMode |-> ##[0:1] !pinsOut.statusPin;
    endproperty
    a_eoc: assert property (p_eoc) else $error("status not low after frame");
    property p_done;
        convDone |-> ##[1:2] pinsOut.statusPin == !intMode;
    endproperty
    a_done: assert property (p_done) else $error("status wrong after done");
    property p_intclr;
        intMode && !pinsOut.statusPin && !pinsIn.csN && $rose(pinsIn.ioClk) |-> ##[1:6] pinsOut.statusPin;
    endproperty
    a_intclr: assert property (p_intclr) else $error("interrupt not cleared by clock rise");
    property p_samp;
        $rose(sampling) |-> muxAddrValid;
    endproperty
    a_samp: assert property (p_samp) else $error("sampling before address");
    property p_addr;
        $rose(muxAddrValid) |-> !sampling && !pinsOut.dataOutOeN;
    endproperty
    a_addr: assert property (p_addr) else $error("address valid at wrong time");
    property p_clr;
        $fell(pinsIn.csN) |-> ##[1:4] !muxAddrValid;
    endproperty
    a_clr: assert property (p_clr) else $error("select fall did not clear state");
endmodule // asc_serial_ctrl_chk
bind asc_serial_ctrl asc_serial_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .pinsIn(pinsIn), .pinsOut(pinsOut),
    .intMode(intMode), .muxAddrValid(muxAddrValid), .sampling(sampling), .convStart(convStart), .convDone(convDone));
`default_nettype wire

/* asc_host_model.sv */
/* Host serial master, mode 0, 120 ns clock period.
 Assumes callers start tasks 1 ns after an mclk edge. */
`default_nettype none
module asc_host_model
    import asc_pkg::*;
(
    // Pins
    output asc_pkg::asc_pins_s pins,
    input  wire logic          dataOut
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 3'b100;
    // Clock stands still outside frames; ends after the last fall with select still low
    task automatic frame(input logic [7:0] cmd, input int edges, output logic [15:0] got);
        got = '0;
        pins.csN = 1'b0;
        for (int i = 0; i < edges; i++) begin
            #40;
            pins.dataIn = (i < 8) ? cmd[7-i] : ~pins.dataIn;
            #40;
            pins.ioClk = 1'b1;
            #20;
            got = {got[14:0], dataOut};
            #20;
            pins.ioClk = 1'b0;
        end
    endtask
    // Line released: toggled so a stale level is never mistaken for data
    task automatic release_cs();
        #40;
        pins.csN = 1'b1;
        pins.dataIn = ~pins.dataIn;
    endtask
endmodule // asc_host_model
`default_nettype wire

/* asc_serial_ctrl_tb.sv */
/* Self-checking bench for asc_serial_ctrl with a mode-0 host model.
 Assumes the 12-edge frame of ASC_DEF_EDGES. */
`default_nettype none
module asc_serial_ctrl_tb;
    import asc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_n, lsbFirst, intMode, convDone, convStart, sampling, muxAddrValid;
    logic [11:0] convResult;
    logic [7:0]  commandByte;
    logic [3:0]  muxAddr;
    asc_pins_s   pinsIn;
    asc_outs_s   pinsOut;
    int          failures, n_tests;
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    asc_serial_ctrl uut (.mclk(mclk), .rst_n(rst_n), .pinsIn(pinsIn), .pinsOut(pinsOut), .lsbFirst(lsbFirst),
        .intMode(intMode), .frameEdges(ASC_DEF_EDGES), .muxAddr(muxAddr), .muxAddrValid(muxAddrValid),
        .commandByte(commandByte), .sampling(sampling), .convStart(convStart), .convDone(convDone),
        .convResult(convResult));
    asc_host_model u_host (.pins(pinsIn), .dataOut(pinsOut.dataOut));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One frame reads the previous result, then the core finishes with a new one
    task automatic frame_conv(input logic [7:0] cmd, input logic [11:0] prev, input logic [11:0] next);
        logic [15:0] got;
        logic [11:0] exp;
        exp = lsbFirst ? {<<{prev}} : prev;
        u_host.frame(cmd, ASC_DEF_EDGES, got);
        check(got[11:0], exp);
        for (int k = 0; k < 20 && convStart !== 1'b1; k++) @(posedge mclk) #1;
        check(convStart, 1'b1);
        check(commandByte, cmd);
        check(muxAddr, cmd[3:0]);
        check(muxAddrValid, 1'b1);
        check(sampling, 1'b0);
        check(pinsOut.statusPin, intMode);
        u_host.release_cs();
        repeat (4) @(posedge mclk) #1;
        check(pinsOut.dataOutOeN, 1'b1);
        convResult = next;
        convDone = 1'b1;
        @(posedge mclk) #1;
        convDone = 1'b0;
        repeat (2) @(posedge mclk) #1;
        check(pinsOut.statusPin, !intMode);
    endtask
    initial begin
        #200000;
        failures++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        lsbFirst = 1'b0;
        intMode = 1'b0;
        convDone = 1'b0;
        convResult = 12'h000;
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        check(pinsOut.statusPin, ASC_STAT_IDLE);
        check(pinsOut.dataOutOeN, 1'b1);
        repeat (4) @(posedge mclk) #1;
        frame_conv(8'hA5, ASC_RES_RST, 12'hC35);
        frame_conv(8'h3C, 12'hC35, 12'h5A1);
        lsbFirst = 1'b1;
        intMode = 1'b1;
        frame_conv(8'hF0, 12'h5A1, 12'h9E6);
        frame_conv(8'h0F, 12'h9E6, 12'h000);
        complete_run();
    end
endmodule // asc_serial_ctrl_tb
`default_nettype wire
